// *** mia_defs.svh ***
/*
 indirect portal constants: addresses, field positions, reset values.
 assumes inclusion by bare name from mia_ext_regs and mia_portal; the package does not include it.
*/
`ifndef MIA_DEFS_SVH
`define MIA_DEFS_SVH
`define MIA_ADDR_CTRL 5'h0D
`define MIA_ADDR_DATA 5'h0E
`define MIA_FUNC_HI 15
`define MIA_FUNC_LO 14
`define MIA_SEL_HI 4
`define MIA_SEL_LO 0
`define MIA_SPACE_AFE 5'h1B
`define MIA_SPACE_RSVD 5'h07
`define MIA_SPACE_SQ 5'h1C
`define MIA_REG_AFE 16'h0000
`define MIA_REG_RSVD_RW 16'h003C
`define MIA_REG_RSVD_RO 16'h003D
`define MIA_REG_SQ 16'h00AC
`define MIA_AMP_HI 7
`define MIA_AMP_LO 4
`define MIA_AMP_RST 4'h2
`define MIA_SQ_HI 14
`define MIA_SQ_LO 8
`define MIA_CTRL_RST 16'h0000
`define MIA_PTR_RST 16'h0000
`endif

// *** mia_pkg.sv ***
/*
 types for the indirect access portal.
 does not include mia_defs.svh and uses none of its constants.
*/
package mia_pkg;
    typedef enum logic [1:0]
    {
        MIA_FN_ADDR,
        MIA_FN_DATA,
        MIA_FN_INC_RW,
        MIA_FN_INC_WR
    } mia_func_e;
    typedef logic [15:0] mia_word_t;
    typedef logic [4:0] mia_sel_t;
endpackage

// *** mia_ext_regs.sv ***
/*
 implemented extended registers behind the portal.
 assumes single-cycle write strobe from the portal logic.
*/
`timescale 1ns/100ps
`include "mia_defs.svh"
module mia_ext_regs
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire mia_pkg::mia_sel_t sel_i,
    input wire mia_pkg::mia_word_t ptr_i,
    input wire logic wr_i,
    input wire mia_pkg::mia_word_t wdata_i,
    input wire logic [6:0] quality_i,
    output mia_pkg::mia_word_t rdata_o,
    output logic [3:0] amplitude_o
);
    import mia_pkg::*;
    typedef struct packed
    {
        mia_word_t afe;
        mia_word_t rsvd;
    } mia_ext_s;
    mia_ext_s st_r;
    mia_ext_s st_nxt;
    logic hit_afe;
    logic hit_rsvd;
    logic hit_sq;
    logic hit_ro;
    assign hit_afe = (sel_i == `MIA_SPACE_AFE) && (ptr_i == `MIA_REG_AFE);
    assign hit_rsvd = (sel_i == `MIA_SPACE_RSVD) && (ptr_i == `MIA_REG_RSVD_RW);
    assign hit_ro = (sel_i == `MIA_SPACE_RSVD) && (ptr_i == `MIA_REG_RSVD_RO);
    assign hit_sq = (sel_i == `MIA_SPACE_SQ) && (ptr_i == `MIA_REG_SQ);
    always_comb
    begin
        st_nxt = st_r;
        if (wr_i && hit_afe)
        begin
            st_nxt.afe = wdata_i;
        end
        if (wr_i && hit_rsvd)
        begin
            st_nxt.rsvd = wdata_i;
        end
        rdata_o = 16'h0000;
        if (hit_afe)
        begin
            rdata_o = st_r.afe;
        end
        else if (hit_rsvd)
        begin
            rdata_o = st_r.rsvd;
        end
        else if (hit_ro)
        begin
            rdata_o = 16'h0000;
        end
        else if (hit_sq)
        begin
            rdata_o[`MIA_SQ_HI:`MIA_SQ_LO] = quality_i;
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= '0;
            st_r.afe[`MIA_AMP_HI:`MIA_AMP_LO] <= `MIA_AMP_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign amplitude_o = st_r.afe[`MIA_AMP_HI:`MIA_AMP_LO];
endmodule // mia_ext_regs

// *** mia_portal.sv ***
/*
 indirect access portal: control and address/data registers, one
 stored pointer per space, post-increment, read data register.
 assumes a management front end giving one-cycle rd/wr strobes
 with a 5-bit standard register address.
*/
// Functional notes
// - portal at standard addresses Dh and Eh
// - 32 spaces, 65536 sixteen-bit registers each
// - function 00: portal reaches stored pointer
// - other functions: portal reaches pointed register
// - function 10 increments after reads, writes
// - function 11 increments after writes only
// - bits 4:0 pick space, reset zero
// - amplitude field bits 7:4, resets 0x2
// - read-only quality index bits 14:8
`timescale 1ns/100ps
`include "mia_defs.svh"
module mia_portal
#(
    parameter int SPACES = 32
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire mia_pkg::mia_word_t reg_wdata_i,
    input wire logic [6:0] rx_quality_index_i,
    output mia_pkg::mia_word_t reg_rdata_o,
    output logic reg_hit_o,
    output logic [3:0] analog_front_end_amp_o
);
    import mia_pkg::*;
    ////////////////////////////////////////////////////////////////
    typedef struct packed
    {
        mia_word_t ctrl;
        mia_word_t rdata;
        logic hit;
        logic [3:0] amp;
    } mia_state_s;
    mia_state_s st_r;
    mia_state_s st_nxt;
    // one pointer per space; kept as a plain array, too wide for the struct
    mia_word_t ptr_r [SPACES];
    mia_word_t ptr_nxt;
    logic ptr_we;
    mia_sel_t sel;
    mia_func_e func;
    logic sel_ctrl;
    logic sel_data;
    logic ext_wr;
    mia_word_t ext_rdata;
    logic [3:0] ext_amp;
    mia_word_t cur_ptr;
    logic ptr_access;
    logic bump_on_wr;
    logic bump_on_rd;
    logic data_wr;
    logic data_rd;
    mia_word_t rd_word;
    mia_word_t ptr_inc;
    ////////////////////////////////////////////////////////////////
    // selector comes from the stored control, never from the bus
    assign sel = st_r.ctrl[`MIA_SEL_HI:`MIA_SEL_LO];
    // all four codes are legal, so no illegal function to trap
    assign func = mia_func_e'(st_r.ctrl[`MIA_FUNC_HI:`MIA_FUNC_LO]);
    assign sel_ctrl = (reg_addr_i == `MIA_ADDR_CTRL);
    assign sel_data = (reg_addr_i == `MIA_ADDR_DATA);
    assign cur_ptr = ptr_r[sel];
    assign data_wr = reg_wr_i && sel_data;
    assign data_rd = reg_rd_i && sel_data;
    // carry dropped on purpose: FFFF steps to 0000
    assign ptr_inc = cur_ptr + 16'h0001;
    // function 00 writes land on the pointer only
    assign ext_wr = reg_wr_i && sel_data && (func != MIA_FN_ADDR);
    mia_ext_regs u_ext
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sel_i(sel),
        .ptr_i(cur_ptr),
        .wr_i(ext_wr),
        .wdata_i(reg_wdata_i),
        .quality_i(rx_quality_index_i),
        .rdata_o(ext_rdata),
        .amplitude_o(ext_amp)
    );
    ////////////////////////////////////////////////////////////////
    // function decode: what the portal reaches and when it bumps
    always_comb
    begin
        ptr_access = 1'b0;
        bump_on_wr = 1'b0;
        bump_on_rd = 1'b0;
        case (func)
            MIA_FN_ADDR:
            begin
                ptr_access = 1'b1;
            end
            MIA_FN_DATA:
            begin
                bump_on_wr = 1'b0;
                bump_on_rd = 1'b0;
            end
            MIA_FN_INC_RW:
            begin
                bump_on_wr = 1'b1;
                bump_on_rd = 1'b1;
            end
            MIA_FN_INC_WR:
            begin
                // reads keep the pointer, so a read may be repeated
                bump_on_wr = 1'b1;
                bump_on_rd = 1'b0;
            end
            default:
            begin
                ptr_access = 1'b0;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////
    // read word, picked before it is registered
    always_comb
    begin
        rd_word = 16'h0000;
        if (sel_ctrl)
        begin
            rd_word = st_r.ctrl;
        end
        else if (sel_data && ptr_access)
        begin
            rd_word = cur_ptr;
        end
        else if (sel_data)
        begin
            rd_word = ext_rdata;
        end
    end
    ////////////////////////////////////////////////////////////////
    // pointer of the selected space: load, bump or keep
    always_comb
    begin
        ptr_we = 1'b0;
        ptr_nxt = cur_ptr;
        if (data_wr && ptr_access)
        begin
            ptr_we = 1'b1;
            ptr_nxt = reg_wdata_i;
        end
        else if (data_wr && bump_on_wr)
        begin
            ptr_we = 1'b1;
            ptr_nxt = ptr_inc;
        end
        else if (data_rd && bump_on_rd)
        begin
            ptr_we = 1'b1;
            ptr_nxt = ptr_inc;
        end
    end
    ////////////////////////////////////////////////////////////////
    // hit and read word registered so the outputs come from flops
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.hit = 1'b0;
        // amp copied once more: one cycle extra lag, clean flop output
        st_nxt.amp = ext_amp;
        // reserved bits stored as written; host keeps them zero
        if (reg_wr_i && sel_ctrl)
        begin
            st_nxt.ctrl = reg_wdata_i;
        end
        if (reg_rd_i)
        begin
            st_nxt.hit = sel_ctrl || sel_data;
            st_nxt.rdata = rd_word;
        end
    end
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= '0;
            st_r.ctrl <= `MIA_CTRL_RST;
            st_r.amp <= `MIA_AMP_RST;
            for (int i = 0; i < SPACES; i++)
            begin
                ptr_r[i] <= `MIA_PTR_RST;
            end
        end
        else
        begin
            st_r <= st_nxt;
            if (ptr_we)
            begin
                ptr_r[sel] <= ptr_nxt;
            end
        end
    end
    assign reg_rdata_o = st_r.rdata;
    assign reg_hit_o = st_r.hit;
    assign analog_front_end_amp_o = st_r.amp;
endmodule // mia_portal

// *** mia_portal_sva.sv ***
/* portal checker: read answers, control and pointer readback.
 sees only the portal's ports. */
`timescale 1ns/100ps
module mia_portal_chk
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire mia_pkg::mia_word_t reg_wdata_i,
    input wire logic [6:0] rx_quality_index_i,
    input wire mia_pkg::mia_word_t reg_rdata_o,
    input wire logic reg_hit_o,
    input wire logic [3:0] analog_front_end_amp_o
);
    import mia_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic wd = reg_wr_i && reg_addr_i == 5'h0D;
    wire logic we = reg_wr_i && reg_addr_i == 5'h0E;
    wire logic rdd = reg_rd_i && reg_addr_i == 5'h0D;
    wire logic rde = reg_rd_i && reg_addr_i == 5'h0E;
    ////////////////////////////////////////////////////////////
    a_hit_on_portal: assert property (rdd || rde |=> reg_hit_o)
        else $error("no hit");
    a_miss_zero: assert property (reg_rd_i && !rdd && !rde |=> !reg_hit_o && !reg_rdata_o)
        else $error("miss answered");
    a_hit_one_pulse: assert property (!reg_rd_i |=> !reg_hit_o)
        else $error("stray hit");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("rdata moved");
    a_ctrl_readback: assert property (wd ##1 rdd |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("ctrl readback");
    a_ptr_readback: assert property (wd && reg_wdata_i[15:14] == 2'b00 ##1 we ##1 rde
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("ptr readback");
    a_amp_cause: assert property ($changed(analog_front_end_amp_o) |-> $past(reg_wr_i, 2))
        else $error("amp moved");
    // space, pointer, data function, then read: the live level shows
    a_quality_shown: assert property (wd && reg_wdata_i == 16'h001C ##1 we && reg_wdata_i ==
        16'h00AC ##1 wd && reg_wdata_i == 16'h401C ##1 rde
        |=> reg_rdata_o[14:8] == $past(rx_quality_index_i)) else $error("quality");
    cover property (wd ##1 we ##1 wd ##1 we);
    cover property (rde ##2 rde);
    cover property ($changed(analog_front_end_amp_o));
endmodule // mia_portal_chk

// *** mia_host.sv ***
/* management host model issuing portal accesses.
 assumes the bench clock; one strobe per edge. */
`timescale 1ns/100ps
module mia_host
(
    input wire logic clk_i,
    input wire mia_pkg::mia_word_t rdata_i,
    input wire logic hit_i,
    output logic [4:0] addr_o = 5'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output mia_pkg::mia_word_t wdata_o = 16'h0000
);
    import mia_pkg::*;
    // answer flag taken with the last read word
    logic hit_seen = 1'b0;
    // write stays up until the next access; caller releases
    task automatic wr(input logic [4:0] a, input mia_word_t d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        rd_o <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] a, output mia_word_t d);
        addr_o <= a;
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
        hit_seen = hit_i;
        @(posedge clk_i);
    endtask
    task automatic point(input mia_sel_t s, input mia_word_t p, input logic [1:0] f);
        wr(5'h0D, {11'h000, s});
        wr(5'h0E, p);
        wr(5'h0D, {f, 9'h000, s});
    endtask
endmodule // mia_host

// *** mia_portal_tb.sv ***
/* bench for the indirect access portal.
 assumes the host model and the bound checker. */
`timescale 1ns/100ps
module mia_portal_tb;
    import mia_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [6:0] rx_quality_index_i = 7'h15;
    logic [4:0] reg_addr_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic reg_hit_o;
    logic [3:0] amp;
    mia_word_t reg_wdata_i;
    mia_word_t reg_rdata_o;
    mia_word_t rv;
    int failures = 0;
    int cmp_count = 0;
    always #5 clk_i = ~clk_i;
    mia_host H (.clk_i(clk_i), .rdata_i(reg_rdata_o), .hit_i(reg_hit_o), .addr_o(reg_addr_i),
        .wr_o(reg_wr_i),
        .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
    mia_portal DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .rx_quality_index_i(rx_quality_index_i), .reg_rdata_o(reg_rdata_o),
        .reg_hit_o(reg_hit_o), .analog_front_end_amp_o(amp));
    task automatic chk(input mia_word_t got, input mia_word_t exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        H.rd(5'h0D, rv); chk(rv, 16'h0000);
        chk_flag(H.hit_seen, 1'b1);
        H.rd(5'h0E, rv); chk(rv, 16'h0000);
        chk({12'h000, amp}, 16'h0002);
        H.rd(5'h03, rv); chk(rv, 16'h0000);
        chk_flag(H.hit_seen, 1'b0);
    endtask
    task automatic t_walk();
        H.wr(5'h0D, 16'h0007); H.wr(5'h0E, 16'h003C);
        H.rd(5'h0E, rv); chk(rv, 16'h003C);
        H.wr(5'h0D, 16'h4007);
        H.rd(5'h0D, rv); chk(rv, 16'h4007);
        H.wr(5'h0E, 16'h0002); H.rd(5'h0E, rv); chk(rv, 16'h0002);
        H.wr(5'h0D, 16'h0007); H.rd(5'h0E, rv); chk(rv, 16'h003C);
    endtask
    task automatic t_incr();
        H.point(5'h07, 16'h003B, 2'b10);
        H.rd(5'h0E, rv); chk(rv, 16'h0000);
        H.rd(5'h0E, rv); chk(rv, 16'h0002);
        H.wr(5'h0E, 16'h1234); H.wr(5'h0D, 16'h0007);
        H.rd(5'h0E, rv); chk(rv, 16'h003E);
        H.point(5'h07, 16'h003C, 2'b11);
        H.rd(5'h0E, rv); H.rd(5'h0E, rv); chk(rv, 16'h0002);
        H.wr(5'h0E, 16'hA5A5); H.wr(5'h0D, 16'h0007);
        H.rd(5'h0E, rv); chk(rv, 16'h003D);
        H.point(5'h07, 16'hFFFF, 2'b10); H.rd(5'h0E, rv); H.wr(5'h0D, 16'h0007);
        H.rd(5'h0E, rv); chk(rv, 16'h0000);
    endtask
    task automatic t_amp_quality();
        H.point(5'h1B, 16'h0000, 2'b01); H.wr(5'h0E, 16'h0070);
        H.rd(5'h0E, rv); chk(rv, 16'h0070);
        @(negedge clk_i); chk({12'h000, amp}, 16'h0007);
        H.point(5'h07, 16'h003C, 2'b01); H.rd(5'h0E, rv); chk(rv, 16'hA5A5);
        rx_quality_index_i <= 7'h2A;
        H.point(5'h1C, 16'h00AC, 2'b01); H.rd(5'h0E, rv);
        chk({9'h000, rv[14:8]}, 16'h002A);
        H.wr(5'h0E, 16'hFFFF); H.rd(5'h0E, rv); chk({9'h000, rv[14:8]}, 16'h002A);
        H.wr(5'h0D, 16'h0007); H.rd(5'h0E, rv); chk(rv, 16'h003C);
        H.point(5'h07, 16'h003D, 2'b01); H.rd(5'h0E, rv); chk(rv, 16'h0000);
    endtask
    initial
    begin
        #50000;
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_walk();
        t_incr();
        t_amp_quality();
        give_verdict();
    end
endmodule // mia_portal_tb
bind mia_portal mia_portal_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .rx_quality_index_i(rx_quality_index_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .analog_front_end_amp_o(analog_front_end_amp_o));
